// ==== src/seeq_encoder.sv ====
// Module: priority pick of one pending event and its code
module seeq_encoder (
    input wire logic [seeq_pkg::NSRC-1:0] pending,
    output logic [seeq_pkg::NSRC-1:0] grant,
    output logic [seeq_pkg::CODE_W-1:0] code,
    output logic any
);
    // Lowest index wins; one event per cycle keeps order stable
    always_comb
    begin
        logic found;
        found = 1'b0;
        grant = '0;
        code = seeq_pkg::C_NONE;
        for (int i = 0; i < seeq_pkg::NSRC; i++)
        begin
            if (pending[i] && !found)
            begin
                found = 1'b1;
                grant[i] = 1'b1;
                code = seeq_pkg::SRC_CODE[i];
            end
        end
        any = found;
    end
endmodule // seeq_encoder

// ==== src/seeq_fifo.sv ====
// Module: first-in first-out store for queued codes
module seeq_fifo #(
    parameter int DEPTH = 16,
    parameter int CW = 16
) (
    input wire logic clock,
    input wire logic resetn,
    seeq_q_if.mem q
);
    localparam int PW = $clog2(DEPTH);
    localparam int KW = $clog2(DEPTH + 1);
    logic [CW-1:0] store [DEPTH];         // Entry array
    logic [PW-1:0] wrPtr_r;
    logic [PW-1:0] rdPtr_r;
    logic [KW-1:0] count_r;
    logic doPush;
    logic doPop;

    assign doPop = q.pop && !q.empty;
    assign doPush = q.push && (!q.full || doPop);
    assign q.rdCode = store[rdPtr_r];
    assign q.count = count_r;
    assign q.full = (count_r == KW'(DEPTH));
    assign q.empty = (count_r == '0);

    // Storage, no reset needed: empty entries are never read out
    always_ff @(posedge clock)
    begin
        if (q.ce && doPush)
            store[wrPtr_r] <= q.wrCode;
    end

    // Pointers and occupancy; wrap handles any depth
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else if (q.ce)
        begin
            if (doPush)
                wrPtr_r <= (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
            if (doPop)
                rdPtr_r <= (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
            if (doPush && !doPop)
                count_r <= count_r + 1'b1;
            else if (doPop && !doPush)
                count_r <= count_r - 1'b1;
        end
    end
endmodule // seeq_fifo

// ==== src/seeq_pkg.sv ====
// Package: widths, queue codes, source indices and state types for the error queue
package seeq_pkg;
    localparam int CODE_W = 16;            // Signed code width
    localparam int QUEUE_DEPTH = 16;       // Default queue depth
    localparam int NSRC = 17;              // Number of event sources
    localparam int ESR_W = 8;              // Event status register width
    // Event status register bit positions
    localparam int ESR_OPC = 0;
    localparam int ESR_QUERY = 2;
    localparam int ESR_DEVICE = 3;
    localparam logic [ESR_W-1:0] ESR_RESET = 8'h00;
    // Queue codes, two's complement
    localparam logic [CODE_W-1:0] C_NONE = 16'h0000;
    localparam logic [CODE_W-1:0] C_SYSTEM = 16'hfeca;    // -310
    localparam logic [CODE_W-1:0] C_MEMORY = 16'hfec9;    // -311
    localparam logic [CODE_W-1:0] C_CALLOST = 16'hfec7;   // -313
    localparam logic [CODE_W-1:0] C_SAVLOST = 16'hfec6;   // -314
    localparam logic [CODE_W-1:0] C_CFGLOST = 16'hfec5;   // -315
    localparam logic [CODE_W-1:0] C_SELFTEST = 16'hfeb6;  // -330
    localparam logic [CODE_W-1:0] C_OVERFLOW = 16'hfea2;  // -350
    localparam logic [CODE_W-1:0] C_COMM = 16'hfe98;      // -360
    localparam logic [CODE_W-1:0] C_FRAMING = 16'hfe96;   // -362
    localparam logic [CODE_W-1:0] C_OVERRUN = 16'hfe95;   // -363
    localparam logic [CODE_W-1:0] C_TIMEOUT = 16'hfe93;   // -365
    localparam logic [CODE_W-1:0] C_QGENERIC = 16'hfe70;  // -400
    localparam logic [CODE_W-1:0] C_QINTR = 16'hfe66;     // -410
    localparam logic [CODE_W-1:0] C_QUNTERM = 16'hfe5c;   // -420
    localparam logic [CODE_W-1:0] C_QDEADLK = 16'hfe52;   // -430
    localparam logic [CODE_W-1:0] C_QINDEF = 16'hfe48;    // -440
    localparam logic [CODE_W-1:0] C_CMDERR = 16'hff9c;    // -100
    localparam logic [CODE_W-1:0] C_OPC = 16'hfce0;       // -800
    // Class range bounds
    localparam logic [CODE_W-1:0] DEV_LO = 16'hfe71;      // -399
    localparam logic [CODE_W-1:0] DEV_HI = 16'hfed4;      // -300
    localparam logic [CODE_W-1:0] QRY_LO = 16'hfe0d;      // -499
    localparam logic [CODE_W-1:0] QRY_HI = 16'hfe70;      // -400
    // Source index order is also the drain priority
    localparam logic [CODE_W-1:0] SRC_CODE [NSRC] = '{C_SYSTEM, C_MEMORY,
        C_CALLOST, C_SAVLOST, C_CFGLOST, C_SELFTEST, C_COMM, C_FRAMING,
        C_OVERRUN, C_TIMEOUT, C_QGENERIC, C_QINTR, C_CMDERR, C_QUNTERM,
        C_QDEADLK, C_QINDEF, C_OPC};
    localparam int S_CMDERR = 12;
    localparam int S_QUNTERM = 13;
    localparam int S_OPC = 16;
    // Operation-complete tracker states
    typedef enum logic [1:0] {OPC_IDLE = 2'b01, OPC_ARMED = 2'b10} seeq_opc_t;
    // Signed range check, shared by the class bits and the checks
    function automatic logic inRange(input logic [CODE_W-1:0] c,
                                     input logic [CODE_W-1:0] lo,
                                     input logic [CODE_W-1:0] hi);
        return ($signed(c) >= $signed(lo)) && ($signed(c) <= $signed(hi));
    endfunction
endpackage

// ==== src/seeq_q_if.sv ====
// Interface: queue storage port between the controller and the FIFO
interface seeq_q_if #(parameter int DEPTH = 16, parameter int CW = 16);
    logic ce;                             // Clock enable
    logic push;                           // Write one code
    logic [CW-1:0] wrCode;                // Code written
    logic pop;                            // Remove oldest
    logic [CW-1:0] rdCode;                // Oldest code
    logic [$clog2(DEPTH+1)-1:0] count;    // Entries held
    logic full;
    logic empty;
    modport ctl(output ce, push, wrCode, pop, input rdCode, count, full, empty);
    modport mem(input ce, push, wrCode, pop, output rdCode, count, full, empty);
endinterface

// ==== src/seeq_top.sv ====
// Module: error/event queue controller with event status bits
////////////////////////////////////////////////////////////////////////////////
module seeq_top #(
    parameter int DEPTH = seeq_pkg::QUEUE_DEPTH
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic sysFault,
    input wire logic memParityFault,
    input wire logic calDataLost,
    input wire logic saveDataLost,
    input wire logic cfgDataLost,
    input wire logic selfTestFail,
    input wire logic serCommFault,
    input wire logic flowCtrlEn,
    input wire logic serFramingFault,
    input wire logic serOverrun,
    input wire logic serTimeout,
    input wire logic queryFault,
    input wire logic newCommand,
    input wire logic respUnread,
    input wire logic respRead,
    input wire logic queryValid,
    input wire logic inBufFull,
    input wire logic outBufFull,
    input wire logic binaryRespSend,
    input wire logic chainedQuery,
    input wire logic indefRespPending,
    input wire logic opcArm,
    input wire logic opsPending,
    input wire logic errRead,
    input wire logic esrClear,
    output logic errValid,
    output logic [seeq_pkg::CODE_W-1:0] errCode,
    output logic [$clog2(DEPTH+1)-1:0] queueCount,
    output logic queueEmpty,
    output logic [seeq_pkg::ESR_W-1:0] esr,
    output logic opcArmed
);
    localparam int KW = $clog2(DEPTH + 1);
    localparam int NS = seeq_pkg::NSRC;
    localparam int CW = seeq_pkg::CODE_W;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    seeq_q_if #(.DEPTH(DEPTH), .CW(CW)) q ();
    logic [NS-1:0] pending_r;             // Events waiting to enter the queue
    logic [NS-1:0] pending_nxt;
    logic [NS-1:0] newEvt;                // Events raised this cycle
    logic [NS-1:0] grant;                 // Event taken this cycle
    logic [CW-1:0] pickCode;              // Its code
    logic anyPend;
    logic queueTight;                     // At most the reserved slot is left
    logic opcDone;                        // Armed and all operations finished
    seeq_pkg::seeq_opc_t opcState_r;
    logic [seeq_pkg::ESR_W-1:0] esr_r;
    logic [seeq_pkg::ESR_W-1:0] esrSet;
    logic errValid_r;
    logic [CW-1:0] errCode_r;

    ////////////////////////////////////////////////////////////////////////////
    // Submodules
    seeq_fifo #(.DEPTH(DEPTH), .CW(CW)) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .q(q.mem)
    );

    seeq_encoder u_enc (
        .pending(pending_r),
        .grant(grant),
        .code(pickCode),
        .any(anyPend)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event capture
    // The last free entry is kept back for the overflow marker and the -430 code
    assign queueTight = (q.count >= KW'(DEPTH - 1));
    assign opcDone = (opcState_r == seeq_pkg::OPC_ARMED) && !opsPending;

    // Raw events mapped to sources, in drain priority order
    always_comb
    begin
        newEvt = '0;
        newEvt[0] = sysFault;
        newEvt[1] = memParityFault;
        newEvt[2] = calDataLost;
        newEvt[3] = saveDataLost;
        newEvt[4] = cfgDataLost;
        newEvt[5] = selfTestFail;
        // Flow control masks line faults the handshake would absorb
        newEvt[6] = serCommFault && !flowCtrlEn;
        newEvt[7] = serFramingFault;
        newEvt[8] = serOverrun;
        newEvt[9] = serTimeout;
        newEvt[10] = queryFault;
        newEvt[11] = newCommand && respUnread;
        // Command error is drained before the unterminated code
        newEvt[seeq_pkg::S_CMDERR] = respRead && !queryValid;
        newEvt[seeq_pkg::S_QUNTERM] = respRead && !queryValid;
        newEvt[14] = binaryRespSend && inBufFull && outBufFull
                     && queueTight;
        newEvt[15] = chainedQuery && indefRespPending;
        newEvt[seeq_pkg::S_OPC] = opcDone;
    end

    // A new event on a source beats the drain of the same source
    assign pending_nxt = (pending_r & ~grant) | newEvt;

    // Pending flags, one per source
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            pending_r <= '0;
        else if (ce)
            pending_r <= pending_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Queue write
    // One code per cycle; the granted event always leaves pending, so a
    // full queue drops it rather than stalling later events
    always_comb
    begin
        q.ce = ce;
        q.push = 1'b0;
        q.wrCode = pickCode;
        if (anyPend && !queueTight)
        begin
            q.push = 1'b1;
        end
        else if (anyPend && !q.full)
        begin
            // Deadlock code may use the last slot, any other becomes -350
            q.push = 1'b1;
            if (pickCode != seeq_pkg::C_QDEADLK)
                q.wrCode = seeq_pkg::C_OVERFLOW;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Queue read
    // Pop only when something is held; an empty read still answers
    assign q.pop = ce && errRead && !q.empty;

    // Read answer: oldest code, or zero for no error
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            errValid_r <= 1'b0;
            errCode_r <= seeq_pkg::C_NONE;
        end
        else if (ce)
        begin
            errValid_r <= errRead;
            if (errRead)
                errCode_r <= q.empty ? seeq_pkg::C_NONE : q.rdCode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation complete tracker
    // Arming while already armed just stays armed
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            opcState_r <= seeq_pkg::OPC_IDLE;
        else if (ce)
        begin
            case (opcState_r)
                seeq_pkg::OPC_IDLE:
                    if (opcArm)
                        opcState_r <= seeq_pkg::OPC_ARMED;
                seeq_pkg::OPC_ARMED:
                    if (opcDone)
                        opcState_r <= seeq_pkg::OPC_IDLE;
                default:
                    opcState_r <= seeq_pkg::OPC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event status register
    // Class bits follow the code actually recorded, so -350 counts as device class
    always_comb
    begin
        esrSet = '0;
        if (q.push)
        begin
            esrSet[seeq_pkg::ESR_DEVICE] = seeq_pkg::inRange(q.wrCode,
                seeq_pkg::DEV_LO, seeq_pkg::DEV_HI);
            esrSet[seeq_pkg::ESR_QUERY] = seeq_pkg::inRange(q.wrCode,
                seeq_pkg::QRY_LO, seeq_pkg::QRY_HI);
        end
        // Completion is reported even if its queue entry was lost
        esrSet[seeq_pkg::ESR_OPC] = opcDone;
    end

    // Sticky bits; a set in the clearing cycle survives the clear
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            esr_r <= seeq_pkg::ESR_RESET;
        else if (ce)
            esr_r <= (esrClear ? '0 : esr_r) | esrSet;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign errValid = errValid_r;
    assign errCode = errCode_r;
    assign queueCount = q.count;
    assign queueEmpty = q.empty;
    assign esr = esr_r;
    assign opcArmed = (opcState_r == seeq_pkg::OPC_ARMED);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Writing a device-class code raises bit 3 next cycle
    property p_dev_bit;
        @(posedge clock) disable iff (!resetn)
        (ce && q.push && seeq_pkg::inRange(q.wrCode, seeq_pkg::DEV_LO,
            seeq_pkg::DEV_HI)) |=> esr_r[seeq_pkg::ESR_DEVICE];
    endproperty
    a_dev_bit: assert property (p_dev_bit)
        else $error("device class bit not set");

    // Writing a query-class code raises bit 2 next cycle
    property p_qry_bit;
        @(posedge clock) disable iff (!resetn)
        (ce && q.push && seeq_pkg::inRange(q.wrCode, seeq_pkg::QRY_LO,
            seeq_pkg::QRY_HI)) |=> esr_r[seeq_pkg::ESR_QUERY];
    endproperty
    a_qry_bit: assert property (p_qry_bit)
        else $error("query class bit not set");

    // Lone system fault into an idle, roomy queue is written next cycle
    property p_sys_code;
        @(posedge clock) disable iff (!resetn)
        (ce && sysFault && pending_r == '0 && q.count == '0)
        ##1 ce |-> q.push && q.wrCode == seeq_pkg::C_SYSTEM;
    endproperty
    a_sys_code: assert property (p_sys_code)
        else $error("system fault code not written");

    // When only the reserved slot is left, ordinary codes become -350
    property p_overflow;
        @(posedge clock) disable iff (!resetn)
        (q.push && queueTight && pickCode != seeq_pkg::C_QDEADLK)
        |-> q.wrCode == seeq_pkg::C_OVERFLOW;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow marker not substituted");

    // Serial comm fault is not queued while flow control is on
    property p_flow_mask;
        @(posedge clock) disable iff (!resetn)
        (ce && !pending_r[6] && flowCtrlEn) |=> !pending_r[6];
    endproperty
    a_flow_mask: assert property (p_flow_mask)
        else $error("comm fault queued with flow control on");

    // Response read without query leaves both codes pending
    property p_unterm;
        @(posedge clock) disable iff (!resetn)
        (ce && respRead && !queryValid)
        |=> pending_r[seeq_pkg::S_CMDERR] && pending_r[seeq_pkg::S_QUNTERM];
    endproperty
    a_unterm: assert property (p_unterm)
        else $error("unterminated read not recorded");

    // Completion step: armed, then work drains, then event and bit 0
    sequence s_opc_armed;
        ce && opcState_r == seeq_pkg::OPC_ARMED;
    endsequence
    sequence s_opc_drained;
        s_opc_armed ##0 !opsPending;
    endsequence
    property p_opc;
        @(posedge clock) disable iff (!resetn)
        s_opc_drained |=> esr_r[seeq_pkg::ESR_OPC]
            && pending_r[seeq_pkg::S_OPC]
            && opcState_r == seeq_pkg::OPC_IDLE;
    endproperty
    a_opc: assert property (p_opc)
        else $error("completion not reported");

    // Read of an empty queue answers zero, a held one the oldest code
    sequence s_read;
        ce && errRead;
    endsequence
    property p_read;
        logic [CW-1:0] expect_v;
        @(posedge clock) disable iff (!resetn)
        (s_read, expect_v = q.empty ? seeq_pkg::C_NONE : q.rdCode)
        |=> errValid && errCode == expect_v;
    endproperty
    a_read: assert property (p_read)
        else $error("wrong read answer");

    // Command over an unread response leaves -410 pending
    property p_intr;
        @(posedge clock) disable iff (!resetn)
        (ce && newCommand && respUnread) |=> pending_r[11];
    endproperty
    a_intr: assert property (p_intr)
        else $error("interrupted query not recorded");

    // Binary reply with every buffer full and the queue tight leaves -430 pending
    property p_deadlk;
        @(posedge clock) disable iff (!resetn)
        (ce && binaryRespSend && inBufFull && outBufFull && queueTight) |=> pending_r[14];
    endproperty
    a_deadlk: assert property (p_deadlk)
        else $error("deadlocked reply not recorded");

    // Query chained after an indefinite reply leaves -440 pending
    property p_indef;
        @(posedge clock) disable iff (!resetn)
        (ce && chainedQuery && indefRespPending) |=> pending_r[15];
    endproperty
    a_indef: assert property (p_indef)
        else $error("chained query not recorded");

    // A queue with no free entry is never written: the new error is lost
    property p_full_drop;
        @(posedge clock) disable iff (!resetn)
        q.full |-> !q.push;
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("write into a full queue");
endmodule // seeq_top

// ==== verif/seeq_host.sv ====
// Remote host controller model: drives the message-exchange handshake lines
module seeq_host (
    input wire logic clock,
    output logic newCommand,
    output logic respUnread,
    output logic respRead,
    output logic queryValid,
    output logic chainedQuery,
    output logic indefRespPending
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////////
    // Idle host: nothing outstanding
    initial {newCommand, respUnread, respRead, queryValid, chainedQuery, indefRespPending} = '0;
    // One message step, raised just after an edge and dropped one cycle later
    task automatic send(input int kind);
        @(posedge clock);
        #1;
        case (kind)
            1: {queryValid, respRead} = 2'b11;          // Reads a reply it asked for
            2: {respUnread, newCommand} = 2'b11;        // Commanded fault: reply left unread
            3: respRead = 1'b1;                         // Commanded fault: read with no query
            4: {indefRespPending, chainedQuery} = 2'b11; // Commanded fault: bad chain
            5: newCommand = 1'b1;
            default: chainedQuery = 1'b1;
        endcase
        @(posedge clock);
        #1;
        {newCommand, respUnread, respRead, queryValid, chainedQuery, indefRespPending} = '0;
    endtask
endmodule // seeq_host

// ==== verif/testbench.sv ====
// Self-checking bench for the error/event queue controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 4; // Small queue so overflow is cheap to reach
    logic clock, resetn, ce, flowCtrlEn, inBufFull, outBufFull, opsPending;
    logic [14:0] ev; // One-cycle strobes; bits 0 to 10 follow the source table, 11 to 14 drive binaryRespSend, opcArm, errRead, esrClear
    wire logic newCommand, respUnread, respRead, queryValid, chainedQuery, indefRespPending;
    logic errValid, queueEmpty, opcArmed;
    logic [15:0] errCode;
    logic [2:0] queueCount;
    logic [7:0] esr, expEsr;
    logic [15:0] mq[$]; // Reference copy of the queue
    logic [15:0] notes[$]; // Expected read answers, oldest first
    int n_errors = 0, checked = 0, seed = 21, k;
    ////////////////////////////////////////////////////////////////////////////////
    seeq_top #(.DEPTH(DEPTH)) i_seeq_top (.clock(clock), .resetn(resetn), .ce(ce),
        .sysFault(ev[0]), .memParityFault(ev[1]), .calDataLost(ev[2]),
        .saveDataLost(ev[3]), .cfgDataLost(ev[4]), .selfTestFail(ev[5]),
        .serCommFault(ev[6]), .flowCtrlEn(flowCtrlEn), .serFramingFault(ev[7]),
        .serOverrun(ev[8]), .serTimeout(ev[9]), .queryFault(ev[10]),
        .newCommand(newCommand), .respUnread(respUnread), .respRead(respRead),
        .queryValid(queryValid), .inBufFull(inBufFull), .outBufFull(outBufFull),
        .binaryRespSend(ev[11]), .chainedQuery(chainedQuery),
        .indefRespPending(indefRespPending), .opcArm(ev[12]), .opsPending(opsPending),
        .errRead(ev[13]), .esrClear(ev[14]), .errValid(errValid), .errCode(errCode),
        .queueCount(queueCount), .queueEmpty(queueEmpty), .esr(esr), .opcArmed(opcArmed));
    seeq_host hostModel (.clock(clock), .newCommand(newCommand), .respUnread(respUnread),
        .respRead(respRead), .queryValid(queryValid), .chainedQuery(chainedQuery),
        .indefRespPending(indefRespPending));
    ////////////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Compare and count
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Reference queue write: last slot takes the overflow code except for -430, full drops
    task automatic qpush(input logic [15:0] c);
        int v;
        if (mq.size() == DEPTH)
            return;
        if (mq.size() == DEPTH - 1 && c !== seeq_pkg::C_QDEADLK)
            c = seeq_pkg::C_OVERFLOW;
        v = $signed(c);
        mq.push_back(c);
        expEsr[3] = expEsr[3] | (v >= -399 && v <= -300);
        expEsr[2] = expEsr[2] | (v >= -499 && v <= -400);
        expEsr[0] = expEsr[0] | (c === seeq_pkg::C_OPC);
    endtask
    // One-cycle strobe on an event line
    task automatic fire(input int i);
        @(posedge clock);
        #1;
        ev[i] = 1'b1;
        @(posedge clock);
        #1;
        ev[i] = 1'b0;
    endtask
    // Let the drain finish, then compare fill level and status bits
    task automatic settle();
        repeat (4) @(posedge clock);
        #1;
        chk("queueCount", 16'(queueCount), 16'(mq.size()));
        chk("queueEmpty", 16'(queueEmpty), 16'(mq.size() == 0));
        chk("esr", 16'(esr), 16'(expEsr));
    endtask
    // Clear status while no event is in flight
    task automatic clr();
        fire(14);
        expEsr = '0;
    endtask
    // Read every entry plus one empty read, which must answer zero
    task automatic drain();
        while (mq.size() > 0)
        begin
            fire(13);
            notes.push_back(mq.pop_front());
        end
        fire(13);
        notes.push_back(seeq_pkg::C_NONE);
        settle();
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Answer watcher: each read answer must match the oldest note
    always @(negedge clock)
        if (errValid === 1'b1)
        begin
            if (notes.size() == 0)
                chk("errValid", 16'h0001, 16'h0000);
            else
                chk("errCode", errCode, notes.pop_front());
        end
    // Hang guard, far beyond the expected run
    initial
    begin
        #60000;
        n_errors++;
        wrap_up();
    end
    // Main sequence
    initial
    begin
        {ce, flowCtrlEn, inBufFull, outBufFull, opsPending} = 5'b10000;
        resetn = 1'b0;
        ev = '0;
        expEsr = '0;
        repeat (3) @(posedge clock);
        #1;
        resetn = 1'b1;
        chk("queueEmpty", 16'(queueEmpty), 16'h0001);
        // Each local fault source alone
        for (int i = 0; i <= 10; i++)
        begin
            clr();
            fire(i);
            qpush(seeq_pkg::SRC_CODE[i]);
            settle();
            drain();
        end
        // Host exchanges, legal and faulty
        for (int h = 1; h <= 6; h++)
        begin
            clr();
            hostModel.send(h);
            if (h == 2)
                qpush(seeq_pkg::C_QINTR);
            if (h == 3)
            begin
                qpush(seeq_pkg::C_CMDERR);
                qpush(seeq_pkg::C_QUNTERM);
            end
            if (h == 4)
                qpush(seeq_pkg::C_QINDEF);
            settle();
            drain();
        end
        // Serial fault with flow control on, and an event with the block frozen
        flowCtrlEn = 1'b1;
        fire(6);
        flowCtrlEn = 1'b0;
        ce = 1'b0;
        fire(0);
        ce = 1'b1;
        settle();
        // Overflow: last slot gets the overflow code, the next one is lost
        clr();
        for (int i = 0; i <= 4; i++)
        begin
            fire(i);
            qpush(seeq_pkg::SRC_CODE[i]);
        end
        settle();
        drain();
        // Binary reply with all buffers full takes the last slot itself
        clr();
        for (int i = 5; i <= 7; i++)
        begin
            fire(i);
            qpush(seeq_pkg::SRC_CODE[i]);
        end
        {inBufFull, outBufFull} = 2'b11;
        fire(11);
        qpush(seeq_pkg::C_QDEADLK);
        {inBufFull, outBufFull} = 2'b00;
        settle();
        drain();
        // Completion tracking: armed while work runs, reported once it ends
        clr();
        opsPending = 1'b1;
        fire(12);
        settle();
        chk("opcArmed", 16'(opcArmed), 16'h0001);
        opsPending = 1'b0;
        qpush(seeq_pkg::C_OPC);
        settle();
        chk("opcArmed", 16'(opcArmed), 16'h0000);
        drain();
        // Random back-to-back faults, read out in batches
        clr();
        for (int j = 0; j < 40; j++)
        begin
            k = $unsigned($random(seed)) % 11;
            fire(k);
            qpush(seeq_pkg::SRC_CODE[k]);
            if (j % 5 == 4)
            begin
                settle();
                drain();
            end
        end
        wrap_up();
    end
endmodule // testbench
